/* File: src/tct_pkg.sv */
// Constants, register map and timing for the thermal clock throttle.
package tct_pkg;
    // Register byte addresses
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_STATUS   = 5'h04;
    localparam logic [4:0] REG_INT_STAT = 5'h08;
    localparam logic [4:0] REG_INT_MASK = 5'h0c;
    // Control register fields
    localparam int CTRL_AUTO_EN_BIT = 0;
    localparam int CTRL_OD_EN_BIT   = 1;
    localparam int CTRL_DUTY_LSB    = 2;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Status register fields
    localparam int STAT_TRIP_BIT   = 0;
    localparam int STAT_HOT_BIT    = 1;
    localparam int STAT_EXT_BIT    = 2;
    localparam int STAT_AUTO_BIT   = 3;
    localparam int STAT_GATE_BIT   = 4;
    // Interrupt status and mask fields
    localparam int INT_RISE_BIT = 0;
    localparam int INT_FALL_BIT = 1;
    localparam logic [1:0] INT_RESET = 2'h0;
    // Duty encoding in eighths
    localparam logic [2:0] DUTY_NONE  = 3'h0;
    localparam logic [2:0] AUTO_DUTY  = 3'h4;
    localparam int         DUTY_STEPS = 8;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int OFF_TIME_NS   = 3000;
    localparam int HYST_TIME_NS  = 1000;
    localparam int OFF_CYC  = (OFF_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : OFF_TIME_NS / CLK_PERIOD_NS;
    localparam int HYST_CYC = (HYST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_LIMIT_CYC = 200;
endpackage

/* File: src/tct_throttle.sv */
// Thermal clock throttle with alarm pin, modulation and Avalon-MM registers.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module tct_throttle #(
    parameter int CNT_W = 16
) (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        trip_in,
    input  wire logic        thermal_alarm_n_in,
    output logic             thermal_alarm_n_out,
    output logic             thermal_alarm_n_oe_out,
    output logic             core_clk_en_out,
    output logic             core_clk_out,
    output logic             irq_out,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [3:0]  avs_byteenable_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);
    import tct_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_OFF, ST_ON} tct_state_e;

    localparam logic [CNT_W-1:0] OFF_LAST  = CNT_W'(OFF_CYC - 1);
    localparam logic [CNT_W-1:0] HYST_LAST = CNT_W'(HYST_CYC - 1);

    // Refuse counters too narrow for the longest on interval
    if (CNT_W < 12 || CNT_W > 31) begin : g_bad_width
        $error("tct_throttle: CNT_W must lie between 12 and 31");
    end

    logic             auto_en_q;
    logic             od_en_q;
    logic [2:0]       duty_q;
    logic [1:0]       int_stat_q;
    logic [1:0]       int_mask_q;
    logic             hot_q;
    logic [CNT_W-1:0] hyst_cnt_q;
    tct_state_e       state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             gate_q;
    logic             gate_l;
    logic             ack_q;
    logic [31:0]      rdata_q;
    logic             ext_req;
    logic             auto_act;
    logic             od_act;
    logic             mod_act;
    logic [2:0]       duty_sel;
    logic [CNT_W-1:0] on_len;
    logic             hot_rise;
    logic             hot_fall;
    logic             hot_prev_q;
    logic             wr_acc;
    logic             rd_acc;

    // On interval for duty k/8 with fixed off interval
    function automatic logic [CNT_W-1:0] on_cycles(input logic [2:0] k);
        int n;
        n = (OFF_CYC * int'(k)) / (DUTY_STEPS - int'(k));
        if (n < 1) begin
            n = 1;
        end
        return CNT_W'(n);
    endfunction

    // Bus handshake: answer on the second edge
    assign wr_acc = avs_write_in & ack_q;
    assign rd_acc = avs_read_in & ~ack_q;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign avs_readdata_out    = rdata_q;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
        end
    end

    // Control and mask registers
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            auto_en_q  <= CTRL_RESET[CTRL_AUTO_EN_BIT];
            od_en_q    <= CTRL_RESET[CTRL_OD_EN_BIT];
            duty_q     <= CTRL_RESET[CTRL_DUTY_LSB +: 3];
            int_mask_q <= INT_RESET;
        end else if (wr_acc && avs_byteenable_in[0]) begin
            if (avs_address_in == REG_CTRL) begin
                auto_en_q <= avs_writedata_in[CTRL_AUTO_EN_BIT];
                od_en_q   <= avs_writedata_in[CTRL_OD_EN_BIT];
                duty_q    <= avs_writedata_in[CTRL_DUTY_LSB +: 3];
            end
            if (avs_address_in == REG_INT_MASK) begin
                int_mask_q <= avs_writedata_in[1:0];
            end
        end
    end

    // Read data, captured on the first edge
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 32'h0;
        end else if (rd_acc) begin
            rdata_q <= 32'h0;
            case (avs_address_in)
                REG_CTRL: begin
                    rdata_q[CTRL_AUTO_EN_BIT]     <= auto_en_q;
                    rdata_q[CTRL_OD_EN_BIT]       <= od_en_q;
                    rdata_q[CTRL_DUTY_LSB +: 3]   <= duty_q;
                end
                REG_STATUS: begin
                    rdata_q[STAT_TRIP_BIT] <= trip_in;
                    rdata_q[STAT_HOT_BIT]  <= hot_q;
                    rdata_q[STAT_EXT_BIT]  <= ext_req;
                    rdata_q[STAT_AUTO_BIT] <= auto_act;
                    rdata_q[STAT_GATE_BIT] <= gate_q;
                end
                REG_INT_STAT: begin
                    rdata_q[1:0] <= int_stat_q;
                end
                REG_INT_MASK: begin
                    rdata_q[1:0] <= int_mask_q;
                end
                default: begin
                    rdata_q <= 32'h0;
                end
            endcase
        end
    end

    // Trip state with exit hysteresis; one threshold for alarm and throttle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hot_q      <= 1'b0;
            hyst_cnt_q <= '0;
        end else if (trip_in) begin
            hot_q      <= 1'b1;
            hyst_cnt_q <= '0;
        end else if (hot_q) begin
            if (hyst_cnt_q == HYST_LAST) begin
                hot_q      <= 1'b0;
                hyst_cnt_q <= '0;
            end else begin
                hyst_cnt_q <= hyst_cnt_q + 1'b1;
            end
        end
    end

    // Alarm pin driven low from trip state only
    assign thermal_alarm_n_out    = 1'b0;
    assign thermal_alarm_n_oe_out = hot_q;

    // External pull-low counts as a throttle request
    assign ext_req  = ~thermal_alarm_n_in & ~hot_q;
    assign auto_act = auto_en_q & (hot_q | ext_req);
    assign od_act   = od_en_q & (duty_q != DUTY_NONE);
    assign mod_act  = auto_act | od_act;
    assign duty_sel = auto_act ? AUTO_DUTY : duty_q;
    assign on_len   = on_cycles(duty_sel);

    // Edge events of the alarm condition
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hot_prev_q <= 1'b0;
        end else begin
            hot_prev_q <= hot_q | ext_req;
        end
    end
    assign hot_rise = (hot_q | ext_req) & ~hot_prev_q;
    assign hot_fall = ~(hot_q | ext_req) & hot_prev_q;

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_stat_q <= INT_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == INT_RISE_BIT && hot_rise) || (i == INT_FALL_BIT && hot_fall)) begin
                    int_stat_q[i] <= 1'b1;
                end else if (wr_acc && avs_byteenable_in[0] && avs_address_in == REG_INT_STAT
                             && avs_writedata_in[i]) begin
                    int_stat_q[i] <= 1'b0;
                end
            end
        end
    end
    assign irq_out = |(int_stat_q & int_mask_q);

    // Modulation: fixed off interval, variable on interval
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            gate_q  <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (mod_act) begin
                        state_q <= ST_OFF;
                        cnt_q   <= '0;
                        gate_q  <= 1'b0;
                    end
                end
                ST_OFF: begin
                    if (cnt_q == OFF_LAST) begin
                        state_q <= ST_ON;
                        cnt_q   <= '0;
                        gate_q  <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_ON: begin
                    if (!mod_act) begin
                        state_q <= ST_IDLE;
                        cnt_q   <= '0;
                    end else if (cnt_q + 1'b1 >= on_len) begin
                        state_q <= ST_OFF;
                        cnt_q   <= '0;
                        gate_q  <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= '0;
                    gate_q  <= 1'b1;
                end
            endcase
        end
    end

    // Gate enable latched while clock low, no runt pulses
    always_latch begin
        if (!clock_in) begin
            gate_l <= gate_q;
        end
    end
    assign core_clk_en_out = gate_q;
    assign core_clk_out    = clock_in & gate_l;

    // Helper: length of the current off interval so far, cleared while the gate is on
    logic [CNT_W-1:0] off_len_q;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            off_len_q <= '0;
        end else begin
            off_len_q <= gate_q ? '0 : off_len_q + 1'b1;
        end
    end

    localparam int START_MAX = START_LIMIT_CYC;

    sequence s_cool_down;
        $fell(trip_in) ##0 hot_q;
    endsequence

    property p_alarm_on_trip;
        @(posedge clock_in) disable iff (!rst_b_in) trip_in |=> thermal_alarm_n_oe_out;
    endproperty
    a_alarm_on_trip: assert property (p_alarm_on_trip) else $error("alarm not driven after trip");

    property p_hysteresis;
        @(posedge clock_in) disable iff (!rst_b_in) s_cool_down |-> thermal_alarm_n_oe_out [*8];
    endproperty
    a_hysteresis: assert property (p_hysteresis) else $error("alarm released before hysteresis");

    property p_alarm_config_free;
        @(posedge clock_in) disable iff (!rst_b_in) thermal_alarm_n_oe_out == hot_q && !thermal_alarm_n_out;
    endproperty
    a_alarm_config_free: assert property (p_alarm_config_free) else $error("alarm not from trip state");

    property p_start_latency;
        @(posedge clock_in) disable iff (!rst_b_in)
            $rose(hot_q) && auto_en_q |-> ##[1:START_MAX] (!gate_q || !auto_en_q);
    endproperty
    a_start_latency: assert property (p_start_latency) else $error("throttle did not start in time");

    property p_off_length;
        @(posedge clock_in) disable iff (!rst_b_in) $rose(gate_q) |-> off_len_q == CNT_W'(OFF_CYC);
    endproperty
    a_off_length: assert property (p_off_length) else $error("off interval length wrong");

    property p_auto_wins;
        @(posedge clock_in) disable iff (!rst_b_in) auto_act |-> on_len == on_cycles(AUTO_DUTY);
    endproperty
    a_auto_wins: assert property (p_auto_wins) else $error("on-demand duty used while hot");

    property p_ext_request;
        @(posedge clock_in) disable iff (!rst_b_in)
            !thermal_alarm_n_in && auto_en_q && state_q == ST_IDLE |=> !gate_q;
    endproperty
    a_ext_request: assert property (p_ext_request) else $error("external alarm ignored");

    property p_no_mod_idle;
        @(posedge clock_in) disable iff (!rst_b_in) state_q == ST_IDLE && !mod_act |=> gate_q;
    endproperty
    a_no_mod_idle: assert property (p_no_mod_idle) else $error("clock gated with no request");

    property p_od_start;
        @(posedge clock_in) disable iff (!rst_b_in) state_q == ST_IDLE && od_act |=> !gate_q;
    endproperty
    a_od_start: assert property (p_od_start) else $error("on-demand did not modulate");

    property p_irq_rise;
        @(posedge clock_in) disable iff (!rst_b_in) hot_rise && int_mask_q[INT_RISE_BIT] |=> irq_out;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("alarm interrupt missing");
endmodule

/* File: tb/tct_board.sv */
// Board model of the alarm wire: pull-up, external pull-down and edge monitor.
`timescale 1ns/1ns
module tct_board (
    input  wire logic dev_oe_in,
    input  wire logic dev_data_in,
    input  wire logic ext_pull_in,
    output logic      wire_level_out,
    output int        edges_out
);
    int cnt = 0;

    // Open-drain wire, pulled up when nobody drives it low
    assign wire_level_out = ((dev_oe_in && !dev_data_in) || ext_pull_in) ? 1'b0 : 1'b1;

    // Monitor counts both alarm transitions
    always @(wire_level_out) begin
        cnt = cnt + 1;
    end
    assign edges_out = cnt;
endmodule

/* File: tb/test_tct_throttle.sv */
// Self-checking bench for the thermal clock throttle.
`timescale 1ns/1ns
module test_tct_throttle;
    import tct_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        trip_in = 1'b0;
    logic        ext_pull = 1'b0;
    logic [4:0]  avs_address_in = 5'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic        level;
    logic        alarm_data;
    logic        alarm_oe;
    logic        clk_en;
    logic        irq;
    logic        core_clk;
    int          core_edges = 0;
    logic [31:0] rdata;
    logic        wreq;
    logic [31:0] rd;
    int          edges;
    int          base;
    int          fails = 0;
    int          total_checks = 0;
    int          n;
    int          lo;
    int          hi;

    tct_throttle u_tct_throttle (.clock_in(clock_in), .rst_b_in(rst_b_in), .trip_in(trip_in),
        .thermal_alarm_n_in(level), .thermal_alarm_n_out(alarm_data), .thermal_alarm_n_oe_out(alarm_oe),
        .core_clk_en_out(clk_en), .core_clk_out(core_clk), .irq_out(irq), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(4'hf),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq));
    tct_board u_tct_board (.dev_oe_in(alarm_oe), .dev_data_in(alarm_data), .ext_pull_in(ext_pull),
        .wire_level_out(level), .edges_out(edges));

    // Free-running 10 MHz clock
    always #50 clock_in = ~clock_in;

    // Gated core clock pulses, counted for the gate checks
    always @(posedge core_clk) begin
        core_edges++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic rnw, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] q);
        int   c;
        logic w;
        @(posedge clock_in);
        avs_address_in <= a;
        avs_read_in <= rnw;
        avs_write_in <= !rnw;
        avs_writedata_in <= wd;
        c = 0;
        do begin
            @(posedge clock_in);
            w = wreq;
            c++;
        end while (w !== 1'b0 && c < 20);
        q = rdata;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (w !== 1'b0) begin
            fails++;
            summarize();
        end
    endtask

    // Counts clock-low samples until the gate enable shows the wanted level
    task automatic wait_en(input logic v, output int c);
        c = 0;
        while (clk_en !== v) begin
            @(negedge clock_in);
            c++;
            if (c > 2000) begin
                fails++;
                summarize();
            end
        end
    endtask

    // Lengths of one full off interval and the following on interval
    task automatic measure(output int off_len, output int on_len);
        int d;
        int e;
        wait_en(1'b1, d);
        wait_en(1'b0, d);
        e = core_edges;
        wait_en(1'b1, off_len);
        check(core_edges - e, 0);
        e = core_edges;
        wait_en(1'b0, on_len);
        check(core_edges - e, on_len);
    endtask

    function automatic int on_cyc(input int k);
        on_cyc = (OFF_CYC * k) / (8 - k);
        if (on_cyc < 1) begin
            on_cyc = 1;
        end
    endfunction

    // Main sequence
    initial begin
        repeat (10) @(posedge clock_in);
        rst_b_in <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b1, REG_INT_STAT, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b1, 5'h10, 32'h0, rd);
        check(rd, 32'h0);
        check(alarm_oe, 1'b0);
        base = edges;
        // Hot die with automatic mode still off
        @(posedge clock_in);
        trip_in <= 1'b1;
        @(posedge clock_in);
        @(negedge clock_in);
        check(alarm_oe, 1'b1);
        check(level, 1'b0);
        repeat (50) @(negedge clock_in);
        check(clk_en, 1'b1);
        bus(1'b1, REG_STATUS, 32'h0, rd);
        check(rd[2:0], 3'h3);
        bus(1'b1, REG_INT_STAT, 32'h0, rd);
        check(rd[1:0], 2'h1);
        check(irq, 1'b0);
        bus(1'b0, REG_INT_MASK, 32'h3, rd);
        @(negedge clock_in);
        check(irq, 1'b1);
        // Firmware enables automatic throttling
        bus(1'b0, REG_CTRL, 32'h1, rd);
        wait_en(1'b0, n);
        check(n <= START_LIMIT_CYC, 1'b1);
        measure(lo, hi);
        check(lo, OFF_CYC);
        check(hi, on_cyc(AUTO_DUTY));
        // On-demand duty 1/8 requested while hot
        bus(1'b0, REG_CTRL, 32'h7, rd);
        measure(lo, hi);
        check(hi, on_cyc(AUTO_DUTY));
        // Cool down and watch the hysteresis
        @(posedge clock_in);
        trip_in <= 1'b0;
        n = 0;
        while (alarm_oe === 1'b1 && n < 50) begin
            @(negedge clock_in);
            n++;
        end
        check(n >= HYST_CYC && n <= HYST_CYC + 2, 1'b1);
        check(edges - base, 2);
        bus(1'b1, REG_INT_STAT, 32'h0, rd);
        check(rd[1:0], 2'h3);
        bus(1'b0, REG_INT_STAT, 32'h3, rd);
        bus(1'b1, REG_INT_STAT, 32'h0, rd);
        check(rd[1:0], 2'h0);
        check(irq, 1'b0);
        // Every on-demand duty setting
        for (int k = 1; k < 8; k++) begin
            bus(1'b0, REG_CTRL, (k << 2) | 2, rd);
            measure(lo, hi);
            check(lo, OFF_CYC);
            check(hi, on_cyc(k));
        end
        bus(1'b0, REG_CTRL, 32'h2, rd);
        wait_en(1'b1, n);
        n = 0;
        repeat (100) begin
            @(negedge clock_in);
            n += (clk_en !== 1'b1);
        end
        check(n, 0);
        // External pull-down, first with automatic mode off
        bus(1'b0, REG_CTRL, 32'h0, rd);
        ext_pull <= 1'b1;
        n = 0;
        repeat (100) begin
            @(negedge clock_in);
            n += (clk_en !== 1'b1);
        end
        check(n, 0);
        check(alarm_oe, 1'b0);
        bus(1'b0, REG_CTRL, 32'h1, rd);
        measure(lo, hi);
        check(lo, OFF_CYC);
        check(hi, on_cyc(AUTO_DUTY));
        bus(1'b1, REG_STATUS, 32'h0, rd);
        check(rd[2], 1'b1);
        ext_pull <= 1'b0;
        summarize();
    end
endmodule
